// ==== rtl/bds_pkg.sv ====
`default_nettype none
package bds_pkg;
  // Organisation select: 1 for 36-bit words, 0 for 18-bit words
  localparam bit ORG_X36 = 1'b1;
  localparam int DATA_W = ORG_X36 ? 36 : 18;
  localparam int MASK_W = ORG_X36 ? 4 : 2;
  localparam int LANE_W = DATA_W / MASK_W;
  localparam int ADDR_W = ORG_X36 ? 19 : 20;
  localparam int BEATS = 4;
  localparam int BURST_W = BEATS * DATA_W;
  localparam int BMASK_W = BEATS * MASK_W;
  localparam int ENTRY_W = ADDR_W + BMASK_W + BURST_W;
  localparam int WBUF_DEPTH = 4;
  localparam logic [1:0] RPH_IDLE = 2'h0;
  localparam logic [1:0] RPH_FIRST = 2'h1;
  localparam logic [1:0] RPH_SECOND = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/bds_fifo.sv ====
`default_nettype none
module bds_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  // Contents, oldest first
  output logic [DEPTH*WIDTH-1:0] peek_data_out,
  output logic [DEPTH-1:0] peek_valid_out
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] count;
  } bds_fifo_st_t;

  bds_fifo_st_t r;
  bds_fifo_st_t next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (r.count != FULL_COUNT);
  assign out_valid_out = (r.count != '0);
  assign out_data_out = mem[r.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.wr = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    next_r.count = r.count + (PW+1)'(push) - (PW+1)'(pop);
    if (!rst_n_in) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    r <= next_r;
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[r.wr] <= in_data_in;
    end
  end

  // Contents view in age order
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_peek
      assign peek_data_out[gi*WIDTH +: WIDTH] = mem[PW'(r.rd + PW'(gi))];
      assign peek_valid_out[gi] = (r.count > (PW+1)'(gi));
    end
  endgenerate

  a_fifo_count_up: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (push && !pop) |=> (r.count == $past(r.count) + 1'b1))
    else $error("fifo count did not rise on push");
  a_fifo_empty_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (r.count == '0) |-> (!out_valid_out && in_ready_out))
    else $error("empty fifo offered data or refused fill");
endmodule
`default_nettype wire

// ==== rtl/bds_sram_port.sv ====
`default_nettype none
module bds_sram_port (
  // System clock and status
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  output logic wbuf_full_out,
  output logic out_clocks_tied_out,
  // Input clock pair
  input wire logic k_clk_in,
  input wire logic k_n_clk_in,
  // Output clock pair
  input wire logic c_clk_in,
  input wire logic c_n_clk_in,
  // Command and address
  input wire logic [bds_pkg::ADDR_W-1:0] addr_bus_in,
  input wire logic rd_sel_n_in,
  input wire logic wr_sel_n_in,
  // Write data and byte masks
  input wire logic [bds_pkg::DATA_W-1:0] wr_data_in,
  input wire logic byte_lane0_mask_n_in,
  input wire logic byte_lane1_mask_n_in,
  input wire logic byte_lane2_mask_n_in,
  input wire logic byte_lane3_mask_n_in,
  // Read data and echo clocks
  output logic [bds_pkg::DATA_W-1:0] rd_data_out,
  output logic return_strobe_true_out,
  output logic return_strobe_inv_out
);
  localparam int DW = bds_pkg::DATA_W;
  localparam int MW = bds_pkg::MASK_W;
  localparam int AW = bds_pkg::ADDR_W;
  localparam int BW = bds_pkg::BURST_W;
  localparam int EW = bds_pkg::BMASK_W;
  localparam int NW = bds_pkg::WBUF_DEPTH;

  typedef struct packed {
    logic rst_meta;
    logic rst_n;
    logic tie_meta;
    logic tied;
    logic s1;
    logic s2;
    logic s3;
    logic [AW-1:0] a1;
    logic [AW-1:0] a2;
    logic [AW-1:0] a3;
    logic [BW-1:0] wdat;
    logic [EW-1:0] wen;
    logic rd_go;
    logic [AW-1:0] raddr;
    logic [BW-1:0] rbuf;
    logic [1:0] rph;
  } bds_link_t;

  typedef struct packed {
    logic full_meta;
    logic full;
    logic tie_meta;
    logic tied;
  } bds_sys_t;

  function automatic logic [BW-1:0] merge_burst(input logic [BW-1:0] base,
                                                input logic [BW-1:0] data,
                                                input logic [EW-1:0] en);
    logic [BW-1:0] res;
    res = base;
    for (int k = 0; k < EW; k++) begin
      if (en[k]) begin
        res[k*bds_pkg::LANE_W +: bds_pkg::LANE_W] = data[k*bds_pkg::LANE_W +: bds_pkg::LANE_W];
      end
    end
    return res;
  endfunction

  bds_link_t r;
  bds_link_t next_r;
  bds_sys_t s;
  bds_sys_t next_s;
  logic [BW-1:0] mem [2**AW];
  logic [DW-1:0] d_neg;
  logic [MW-1:0] m_neg;
  logic [MW-1:0] mask_n;
  logic push_valid;
  logic push_ready;
  logic [BW-1:0] push_burst;
  logic [EW-1:0] push_en;
  logic pop_valid;
  logic pop_ready;
  logic pop_fire;
  logic [bds_pkg::ENTRY_W-1:0] pop_entry;
  logic [NW*bds_pkg::ENTRY_W-1:0] peek_data;
  logic [NW-1:0] peek_valid;
  logic [BW-1:0] coh_word;
  logic out_clk;
  logic out_n_clk;
  logic [DW-1:0] q_pos;
  logic [DW-1:0] q_neg;

  assign mask_n = MW'({byte_lane3_mask_n_in, byte_lane2_mask_n_in,
                       byte_lane1_mask_n_in, byte_lane0_mask_n_in});

  // Beats 2 and 4 with their masks on the complementary input edge
  always_ff @(posedge k_n_clk_in) begin
    d_neg <= wr_data_in;
    m_neg <= ~mask_n;
  end

  // Assembled burst with beat 4 taken straight from the complementary capture
  always_comb begin
    push_burst = r.wdat;
    push_en = r.wen;
    push_burst[3*DW +: DW] = d_neg;
    push_en[3*MW +: MW] = m_neg;
  end

  assign push_valid = r.s3;

  // Array read with buffered writes laid over it, oldest first
  always_comb begin
    coh_word = mem[r.raddr];
    for (int e = 0; e < NW; e++) begin
      if (peek_valid[e] &&
          peek_data[e*bds_pkg::ENTRY_W + EW + BW +: AW] == r.raddr) begin
        coh_word = merge_burst(coh_word, peek_data[e*bds_pkg::ENTRY_W +: BW],
                               peek_data[e*bds_pkg::ENTRY_W + BW +: EW]);
      end
    end
    if (r.s3 && r.a3 == r.raddr) begin
      coh_word = merge_burst(coh_word, push_burst, push_en);
    end
  end

  // Link side state
  always_comb begin
    next_r = r;
    next_r.rst_meta = rst_n_in;
    next_r.rst_n = r.rst_meta;
    next_r.tie_meta = c_clk_in & c_n_clk_in;
    next_r.tied = r.tie_meta;
    // Write pipeline: command, beat 1, beats 2 and 3, then push with beat 4
    next_r.s1 = !wr_sel_n_in;
    next_r.a1 = addr_bus_in;
    next_r.s2 = r.s1;
    next_r.a2 = r.a1;
    next_r.s3 = r.s2;
    next_r.a3 = r.a2;
    if (r.s1) begin
      next_r.wdat[0 +: DW] = wr_data_in;
      next_r.wen[0 +: MW] = ~mask_n;
    end
    if (r.s2) begin
      next_r.wdat[DW +: DW] = d_neg;
      next_r.wen[MW +: MW] = m_neg;
      next_r.wdat[2*DW +: DW] = wr_data_in;
      next_r.wen[2*MW +: MW] = ~mask_n;
    end
    // Read pipeline: command, array fetch, two output phases
    next_r.rd_go = !rd_sel_n_in;
    if (!rd_sel_n_in) begin
      next_r.raddr = addr_bus_in;
    end
    if (r.rd_go) begin
      next_r.rbuf = coh_word;
      next_r.rph = bds_pkg::RPH_FIRST;
    end else if (r.rph == bds_pkg::RPH_FIRST) begin
      next_r.rph = bds_pkg::RPH_SECOND;
    end else begin
      next_r.rph = bds_pkg::RPH_IDLE;
    end
    if (!r.rst_n) begin
      next_r.s1 = 1'b0;
      next_r.s2 = 1'b0;
      next_r.s3 = 1'b0;
      next_r.wen = '0;
      next_r.rd_go = 1'b0;
      next_r.rph = bds_pkg::RPH_IDLE;
    end
  end

  always_ff @(posedge k_clk_in) begin
    r <= next_r;
  end

  // Write buffer between burst assembly and the array
  bds_fifo #(
    .WIDTH(bds_pkg::ENTRY_W),
    .DEPTH(NW)
  ) u_wbuf (
    .clk_in(k_clk_in),
    .rst_n_in(r.rst_n),
    .in_valid_in(push_valid),
    .in_data_in({r.a3, push_en, push_burst}),
    .in_ready_out(push_ready),
    .out_valid_out(pop_valid),
    .out_data_out(pop_entry),
    .out_ready_in(pop_ready),
    .peek_data_out(peek_data),
    .peek_valid_out(peek_valid)
  );

  // Array port is yielded to a read fetch
  assign pop_ready = !r.rd_go;
  assign pop_fire = pop_valid & pop_ready;

  always_ff @(posedge k_clk_in) begin
    if (pop_fire) begin
      mem[pop_entry[EW+BW +: AW]] <= merge_burst(mem[pop_entry[EW+BW +: AW]],
                                                 pop_entry[0 +: BW],
                                                 pop_entry[BW +: EW]);
    end
  end

  // Output timing pair falls back to the input pair when both are held high
  assign out_clk = r.tied ? k_clk_in : c_clk_in;
  assign out_n_clk = r.tied ? k_n_clk_in : c_n_clk_in;

  always_ff @(posedge out_n_clk) begin
    if (r.rph == bds_pkg::RPH_FIRST) begin
      q_neg <= r.rbuf[0 +: DW];
    end else if (r.rph == bds_pkg::RPH_SECOND) begin
      q_neg <= r.rbuf[2*DW +: DW];
    end else begin
      q_neg <= '0;
    end
  end

  always_ff @(posedge out_clk) begin
    if (r.rph == bds_pkg::RPH_FIRST) begin
      q_pos <= r.rbuf[DW +: DW];
    end else if (r.rph == bds_pkg::RPH_SECOND) begin
      q_pos <= r.rbuf[3*DW +: DW];
    end else begin
      q_pos <= '0;
    end
  end

  assign rd_data_out = out_clk ? q_pos : q_neg;
  assign return_strobe_true_out = out_clk;
  assign return_strobe_inv_out = out_n_clk;

  // System side status
  always_comb begin
    next_s = s;
    next_s.full_meta = !push_ready;
    next_s.full = s.full_meta;
    next_s.tie_meta = r.tied;
    next_s.tied = s.tie_meta;
    if (!rst_n_in) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    s <= next_s;
  end

  assign wbuf_full_out = s.full;
  assign out_clocks_tied_out = s.tied;

  a_wr_push_time: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (!wr_sel_n_in) |-> ##3 push_valid)
    else $error("write burst not pushed three cycles after command");
  a_beat1_capture: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.s1 |=> (r.wdat[0 +: DW] == $past(wr_data_in)))
    else $error("beat 1 not taken on true edge");
  a_beat3_mask: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.s2 |=> (r.wen[2*MW +: MW] == $past(~mask_n)) && (r.wdat[2*DW +: DW] == $past(wr_data_in)))
    else $error("beat 3 data or mask lost");
  a_beat2_neg: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.s2 |=> (r.wdat[DW +: DW] == $past(d_neg)))
    else $error("beat 2 not taken from complementary edge");
  a_rd_phase_seq: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (!rd_sel_n_in) |-> ##1 r.rd_go ##1 (r.rph == bds_pkg::RPH_FIRST))
    else $error("read output phase late");
  a_rd_second: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (r.rph == bds_pkg::RPH_FIRST && !r.rd_go) |=> (r.rph == bds_pkg::RPH_SECOND))
    else $error("read second phase missing");
  a_drain_yield: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (r.rd_go && pop_valid) |=> (pop_valid && pop_entry == $past(pop_entry)))
    else $error("buffered entry lost during read fetch");
  a_tie_detect: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (c_clk_in && c_n_clk_in) [*3] |-> r.tied)
    else $error("held output clocks not detected");
  a_coherent_read: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (r.rd_go && r.s3 && r.a3 == r.raddr && (&push_en)) |=> (r.rbuf == $past(push_burst)))
    else $error("read missed buffered write");

  // Write path and pipeline reset
  a_push_addr: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    push_valid |-> (r.a3 == $past(addr_bus_in, 3)))
    else $error("pushed burst carries wrong address");
  a_push_s2: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    push_valid |-> $past(r.s2))
    else $error("burst pushed without full assembly");
  a_wdat_hold: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (!r.s1 && !r.s2) |=> $stable(r.wdat))
    else $error("burst data changed outside a write");
  a_reset_clear: assert property (@(posedge k_clk_in)
    !r.rst_n |=> (!r.s1 && !r.s2 && !r.s3 && r.rph == bds_pkg::RPH_IDLE))
    else $error("pipelines not cleared by reset");

  // Read path
  a_rd_addr: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (!rd_sel_n_in) |=> (r.raddr == $past(addr_bus_in)))
    else $error("read address not taken");
  a_single_fetch: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.rd_go |=> !r.rd_go)
    else $error("fetch repeated on next edge");
  a_rph_idle: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (r.rph == bds_pkg::RPH_SECOND && !r.rd_go) |=> (r.rph == bds_pkg::RPH_IDLE))
    else $error("read phase did not end");

  // Output registers and output clock fallback release
  a_beat1_out: assert property (@(posedge out_clk) disable iff (!r.rst_n)
    (r.rph == bds_pkg::RPH_FIRST) |-> (q_neg == r.rbuf[0 +: DW]))
    else $error("beat 1 not launched");
  a_beat2_out: assert property (@(posedge out_n_clk) disable iff (!r.rst_n)
    (r.rph == bds_pkg::RPH_SECOND) |-> (q_pos == r.rbuf[DW +: DW]))
    else $error("beat 2 not launched");
  a_beat3_out: assert property (@(posedge out_clk) disable iff (!r.rst_n)
    (r.rph == bds_pkg::RPH_SECOND) |-> (q_neg == r.rbuf[2*DW +: DW]))
    else $error("beat 3 not launched");
  a_tie_release: assert property (@(posedge k_clk_in) disable iff (!r.rst_n)
    (!(c_clk_in && c_n_clk_in)) [*3] |-> !r.tied)
    else $error("running output clocks taken as held");

  // Scenario coverage

  c_write_push: cover property (@(posedge k_clk_in) disable iff (!r.rst_n)
    push_valid && push_ready);
  c_read_out: cover property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.rph == bds_pkg::RPH_SECOND);
  c_concurrent: cover property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.s2 && r.rph == bds_pkg::RPH_FIRST);
  c_tied_mode: cover property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.tied && r.rd_go);
  c_coherent_hit: cover property (@(posedge k_clk_in) disable iff (!r.rst_n)
    r.rd_go && r.s3 && r.a3 == r.raddr);
endmodule
`default_nettype wire

// ==== tb/bds_ctrl_model.sv ====
`default_nettype none
module bds_ctrl_model (
  // Link clock pair
  output logic k_clk_out,
  output logic k_n_clk_out,
  // Command, address and write beats
  output logic [bds_pkg::ADDR_W-1:0] addr_out,
  output logic rd_sel_n_out,
  output logic wr_sel_n_out,
  output logic [bds_pkg::DATA_W-1:0] wr_data_out,
  output logic [bds_pkg::MASK_W-1:0] mask_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = bds_pkg::DATA_W;
  localparam int MW = bds_pkg::MASK_W;
  typedef struct packed {
    logic [1:0] kind;
    logic [bds_pkg::ADDR_W-1:0] addr;
    logic [bds_pkg::BURST_W-1:0] data;
    logic [bds_pkg::BMASK_W-1:0] mask;
  } bds_cmd_t;
  bds_cmd_t cmd_q[$];
  logic [MW+DW-1:0] beat_at[int];
  int pt;
  // One entry per true edge: 0 idle, 1 read, 2 write
  task automatic push_cmd(input logic [1:0] kind, input logic [bds_pkg::ADDR_W-1:0] a,
      input logic [bds_pkg::BURST_W-1:0] d, input logic [bds_pkg::BMASK_W-1:0] m);
    cmd_q.push_back('{kind, a, d, m});
  endtask
  // Free-running link clock, unrelated in phase to the system clock
  initial begin
    k_clk_out = 1'b0;
    #7;
    forever #80 k_clk_out = ~k_clk_out;
  end
  assign k_n_clk_out = ~k_clk_out;
  // Drive points sit a quarter cycle after every link clock edge
  initial begin : drive
    bds_cmd_t c;
    pt = 0;
    rd_sel_n_out = 1'b1;
    wr_sel_n_out = 1'b1;
    addr_out = '0;
    {mask_n_out, wr_data_out} = '1;
    forever begin
      @(k_clk_out);
      #40;
      pt++;
      if (!k_clk_out && cmd_q.size() > 0) begin
        c = cmd_q.pop_front();
        addr_out = (c.kind == 2'h0) ? ~addr_out : c.addr;
        rd_sel_n_out = (c.kind != 2'h1);
        wr_sel_n_out = (c.kind != 2'h2);
        if (c.kind == 2'h2) begin
          for (int b = 0; b < 4; b++) begin
            beat_at[pt+2+b] = {c.mask[b*MW +: MW], c.data[b*DW +: DW]};
          end
        end
      end else begin
        rd_sel_n_out = 1'b1;
        wr_sel_n_out = 1'b1;
        addr_out = ~addr_out;
      end
      if (beat_at.exists(pt)) begin
        {mask_n_out, wr_data_out} = beat_at[pt];
      end else begin
        {mask_n_out, wr_data_out} = ~{mask_n_out, wr_data_out};
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/bds_sram_port_tb.sv ====
`default_nettype none
module bds_sram_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = bds_pkg::ADDR_W;
  localparam int DW = bds_pkg::DATA_W;
  logic clk_sys_in, rst_n_in, c_tied, k_clk, k_n_clk, c_clk, c_n_clk;
  logic rd_sel_n, wr_sel_n, wbuf_full, tied, echo_t, echo_i;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data, rd_data;
  logic [3:0] mask_n;
  logic [DW-1:0] exp_q[$];
  logic [DW-1:0] ref_mem[int];
  logic [AW-1:0] a[6];
  int fails, n_tests;

  assign c_clk = c_tied | k_clk;
  assign c_n_clk = c_tied | k_n_clk;

  bds_ctrl_model ctrl_u (.k_clk_out(k_clk), .k_n_clk_out(k_n_clk), .addr_out(addr),
    .rd_sel_n_out(rd_sel_n), .wr_sel_n_out(wr_sel_n), .wr_data_out(wr_data),
    .mask_n_out(mask_n));
  bds_sram_port dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .wbuf_full_out(wbuf_full), .out_clocks_tied_out(tied), .k_clk_in(k_clk),
    .k_n_clk_in(k_n_clk), .c_clk_in(c_clk), .c_n_clk_in(c_n_clk), .addr_bus_in(addr),
    .rd_sel_n_in(rd_sel_n), .wr_sel_n_in(wr_sel_n), .wr_data_in(wr_data),
    .byte_lane0_mask_n_in(mask_n[0]), .byte_lane1_mask_n_in(mask_n[1]),
    .byte_lane2_mask_n_in(mask_n[2]), .byte_lane3_mask_n_in(mask_n[3]),
    .rd_data_out(rd_data), .return_strobe_true_out(echo_t),
    .return_strobe_inv_out(echo_i));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic idle;
    ctrl_u.push_cmd(2'h0, '0, '0, '1);
  endtask

  // Write a random burst and merge the enabled lanes into the reference
  task automatic wr(input logic [AW-1:0] ad, input logic [bds_pkg::BMASK_W-1:0] m);
    logic [bds_pkg::BURST_W-1:0] d;
    logic [DW-1:0] w;
    for (int b = 0; b < 4; b++) begin
      w = {4'($urandom()), $urandom()};
      d[b*DW +: DW] = w;
      if (!ref_mem.exists(int'(ad)*4+b)) ref_mem[int'(ad)*4+b] = 'x;
      for (int j = 0; j < 4; j++) begin
        if (!m[b*4+j]) ref_mem[int'(ad)*4+b][j*9 +: 9] = w[j*9 +: 9];
      end
    end
    ctrl_u.push_cmd(2'h2, ad, d, m);
  endtask

  task automatic rd(input logic [AW-1:0] ad);
    for (int b = 0; b < 4; b++) exp_q.push_back(ref_mem[int'(ad)*4+b]);
    ctrl_u.push_cmd(2'h1, ad, '0, '1);
  endtask

  // Samples each beat a quarter cycle after it is launched
  task automatic watch_burst;
    logic [DW-1:0] e;
    #280;
    for (int b = 0; b < 4; b++) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      chk(rd_data, e);
      chk(DW'(echo_t), DW'(b % 2));
      chk(DW'(echo_i), DW'(1 - b % 2));
      #80;
    end
  endtask

  always @(posedge k_clk) begin
    if (rd_sel_n === 1'b0 && rst_n_in === 1'b1) begin
      fork
        watch_burst();
      join_none
    end
  end

  task automatic settle(input string name);
    int i;
    i = 0;
    while (ctrl_u.cmd_q.size() > 0 && i < 400) begin
      @(posedge k_clk);
      i++;
    end
    if (i == 400) begin
      fails++;
      report_and_stop();
    end else begin
      repeat (6) @(posedge k_clk);
      $display("test %s done", name);
    end
  endtask

  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst_n_in = 1'b0;
    c_tied = 1'b0;
    fails = 0;
    n_tests = 0;
    void'($urandom(35770));
    repeat (6) @(posedge k_clk);
    @(negedge clk_sys_in) rst_n_in = 1'b1;
    repeat (4) @(posedge k_clk);
    chk(DW'(wbuf_full), '0);
    chk(DW'(tied), '0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) a[i] = {16'($urandom()), 3'(i)};
    // Writes and reads on alternating edges, each every two cycles
    for (int i = 0; i < 6; i++) begin
      wr(a[i], '0);
      if (i > 0) rd(a[i-1]);
      else idle();
    end
    idle();
    idle();
    rd(a[5]);
    settle("interleave");
    // Random per-beat lane masks, read back while still buffered
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 16'($urandom()));
      idle();
      idle();
      rd(a[i]);
    end
    wr(a[0], '0);
    idle();
    rd(a[0]);
    settle("byte masks");
    @(negedge clk_sys_in) c_tied = 1'b1;
    repeat (8) @(posedge k_clk);
    chk(DW'(tied), DW'(1));
    for (int i = 0; i < 6; i++) begin
      rd(a[i]);
      idle();
    end
    settle("tied output clocks");
    chk(DW'(wbuf_full), '0);
    report_and_stop();
  end
endmodule
`default_nettype wire
